/* File: logic/keypad_pkg.sv */
package keypad_pkg;

  localparam int unsigned LINE_COUNT = 8;
  localparam int unsigned SYNC_STAGES = 2;

  typedef logic [7:0] sfr_addr_t;
  typedef logic [7:0] sfr_data_t;

  // Direct addresses of the three registers of the unit.
  localparam sfr_addr_t POLARITY_ADDR = 8'hfd;
  localparam sfr_addr_t ENABLE_ADDR = 8'hfe;
  localparam sfr_addr_t FLAGS_ADDR = 8'hff;

  // Reset values.
  localparam sfr_data_t POLARITY_RESET = 8'h00;
  localparam sfr_data_t ENABLE_RESET = 8'h00;
  localparam sfr_data_t FLAGS_RESET = 8'h00;
  localparam sfr_data_t UNMAPPED_READ = 8'h00;

endpackage

/* File: logic/line_sync.sv */
`timescale 1ns/10ps
`default_nettype none

module line_sync #(
  parameter int unsigned WIDTH = 8
) (
  input wire logic sys_clk, // Core clock.
  input wire logic rstn, // Asynchronous reset, active low.
  input wire logic [WIDTH-1:0] async_in, // Levels from outside the clock domain.
  output logic [WIDTH-1:0] sync_out // Levels after two flip-flops.
);

  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] stable_ff;

  // Each line gets its own pair of flops; the first is read by the second only.
  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi++) begin : g_line
      always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
          meta_ff[gi] <= 1'b0;
          stable_ff[gi] <= 1'b0;
        end else begin
          meta_ff[gi] <= async_in[gi];
          stable_ff[gi] <= meta_ff[gi];
        end
      end
    end
  endgenerate

  assign sync_out = stable_ff;

endmodule

`default_nettype wire

/* File: logic/keypad_level_interrupt_unit.sv */
// What this block does
// - Eight input lines, each with its own high or low level detection choice.
// - Detection inputs are the alternate function of the first port's pins.
// - An enabled detected level can wake the device from idle and power-down.
// - Software sees exactly three registers: polarity, enable mask and flags.
// - Eight independent sources share one common interrupt request.
// - A detected level records a flag; only masked-in flags request service.
// - A global enable input gates the combined request on or off.
// - Polarity register at FDh, reset 00h, bit n for line n.
// - Enable mask register at FEh, reset 00h, bit n enables line n.
// - Flag register at FFh, reset 00h, bit n is the flag of line n.
// - Any subset of lines may be used; disabled lines stay plain port pins.
// - Polarity bit clear detects low level; set detects high level.
// - Mask bit clear leaves a plain pin; set lets its flag request service.
// - Flags are read-only, set by hardware, cleared by reading the register.
`timescale 1ns/10ps
`default_nettype none

module keypad_level_interrupt_unit (
  input wire logic sys_clk, // Core clock, 200 MHz.
  input wire logic rstn, // System reset, asynchronous, active low.
  input wire logic [keypad_pkg::LINE_COUNT-1:0] port_one_pins, // Port pin levels.
  input wire keypad_pkg::sfr_addr_t sfr_addr, // Direct address of the access.
  input wire logic sfr_wr, // Write strobe, one cycle.
  input wire logic sfr_rd, // Read strobe, one cycle.
  input wire keypad_pkg::sfr_data_t sfr_wdata, // Write data.
  output var keypad_pkg::sfr_data_t sfr_rdata, // Read data, one cycle after the strobe.
  input wire logic keypad_global_enable, // Global enable bit from the aux enable reg.
  output logic expanded_external_interrupt, // Shared interrupt request, level.
  output logic wake_request, // Asynchronous wake from low-power modes.
  output logic [keypad_pkg::LINE_COUNT-1:0] line_alt_active // Pins taken by the unit.
);
  import keypad_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////

  logic [LINE_COUNT-1:0] line_polarity_select_ff;
  logic [LINE_COUNT-1:0] line_enable_mask_ff;
  logic [LINE_COUNT-1:0] line_detect_flags_ff;
  logic [LINE_COUNT-1:0] nxt_line_detect_flags;
  sfr_data_t sfr_rdata_ff;
  sfr_data_t nxt_sfr_rdata;
  logic [LINE_COUNT-1:0] pins_sync;
  logic [LINE_COUNT-1:0] level_match;
  logic [LINE_COUNT-1:0] raw_match;
  logic wr_polarity;
  logic wr_enable;
  logic rd_flags;

  // Decodes whether an access hits a given direct address.
  function automatic logic addr_hit(input sfr_addr_t addr, input sfr_addr_t target);
    addr_hit = (addr == target);
  endfunction

  ////////////////////////////////////////////////////////////////////////////////

  line_sync #(
    .WIDTH(LINE_COUNT)
  ) u_line_sync (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .async_in(port_one_pins),
    .sync_out(pins_sync)
  );

  // A line matches when its level equals its polarity bit.
  assign level_match = ~(pins_sync ^ line_polarity_select_ff);

  ////////////////////////////////////////////////////////////////////////////////

  assign wr_polarity = sfr_wr && addr_hit(sfr_addr, POLARITY_ADDR);
  assign wr_enable = sfr_wr && addr_hit(sfr_addr, ENABLE_ADDR);
  assign rd_flags = sfr_rd && addr_hit(sfr_addr, FLAGS_ADDR);

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      line_polarity_select_ff <= POLARITY_RESET;
    end else if (wr_polarity) begin
      line_polarity_select_ff <= sfr_wdata;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      line_enable_mask_ff <= ENABLE_RESET;
    end else if (wr_enable) begin
      line_enable_mask_ff <= sfr_wdata;
    end
  end

  // A read clears the flags, but a level seen in the same cycle sets its flag
  // again, so no detection is lost. Writes to the flag address are ignored.
  always_comb begin
    nxt_line_detect_flags = line_detect_flags_ff;
    if (rd_flags) begin
      nxt_line_detect_flags = '0;
    end
    nxt_line_detect_flags = nxt_line_detect_flags | level_match;
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      line_detect_flags_ff <= FLAGS_RESET;
    end else begin
      line_detect_flags_ff <= nxt_line_detect_flags;
    end
  end

  // Only the three addresses answer; anything else reads as zero.
  always_comb begin
    if (addr_hit(sfr_addr, POLARITY_ADDR)) begin
      nxt_sfr_rdata = line_polarity_select_ff;
    end else if (addr_hit(sfr_addr, ENABLE_ADDR)) begin
      nxt_sfr_rdata = line_enable_mask_ff;
    end else if (addr_hit(sfr_addr, FLAGS_ADDR)) begin
      nxt_sfr_rdata = line_detect_flags_ff;
    end else begin
      nxt_sfr_rdata = UNMAPPED_READ;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      sfr_rdata_ff <= UNMAPPED_READ;
    end else if (sfr_rd) begin
      sfr_rdata_ff <= nxt_sfr_rdata;
    end
  end

  assign sfr_rdata = sfr_rdata_ff;

  ////////////////////////////////////////////////////////////////////////////////

  // All eight sources fold into one request line.
  assign expanded_external_interrupt =
    keypad_global_enable && |(line_detect_flags_ff & line_enable_mask_ff);

  // Disabled lines are left to the port as ordinary pins.
  assign line_alt_active = line_enable_mask_ff;

  // The clock is stopped in power-down, so wake must come straight from the pins.
  // It is a glitch-prone asynchronous level; the power controller must filter it.
  assign raw_match = ~(port_one_pins ^ line_polarity_select_ff) & line_enable_mask_ff;
  assign wake_request = |raw_match;

  ////////////////////////////////////////////////////////////////////////////////

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rstn);

  a_flag_records: assert property (
    (level_match != '0) |=>
      ((line_detect_flags_ff & $past(level_match)) == $past(level_match)))
    else $error("Detected level did not set its flag.");

  a_read_clears: assert property (
    (rd_flags && level_match == '0) |=> (line_detect_flags_ff == '0))
    else $error("Reading the flag register did not clear the flags.");

  a_flags_hold: assert property (
    (!rd_flags && line_detect_flags_ff != '0) |=>
      ((line_detect_flags_ff & $past(line_detect_flags_ff)) == $past(line_detect_flags_ff)))
    else $error("A flag dropped without a read.");

  a_flag_readback: assert property (
    rd_flags |=> (sfr_rdata == $past(line_detect_flags_ff)))
    else $error("Flag read returned the wrong value.");

  a_polarity_write: assert property (
    (sfr_wr && sfr_addr == POLARITY_ADDR) |=> (line_polarity_select_ff == $past(sfr_wdata)))
    else $error("Polarity register did not take the write.");

  a_mask_write: assert property (
    (sfr_wr && sfr_addr == ENABLE_ADDR) ##1 !sfr_wr
      ##1 (sfr_rd && sfr_addr == ENABLE_ADDR && !sfr_wr)
      |=> (sfr_rdata == $past(sfr_wdata, 3)))
    else $error("Enable mask did not read back what was written.");

  // Software may poll the read data long after the strobe, so it must not drift.
  a_rdata_hold: assert property (
    !sfr_rd |=> $stable(sfr_rdata))
    else $error("Read data changed without a read strobe.");

  a_irq_raised: assert property (
    (keypad_global_enable && (line_detect_flags_ff & line_enable_mask_ff) != '0)
      |-> expanded_external_interrupt)
    else $error("Enabled flag with global enable gave no request.");

  a_unmapped_zero: assert property (
    (sfr_rd && sfr_addr < POLARITY_ADDR) |=> (sfr_rdata == UNMAPPED_READ))
    else $error("Unmapped address did not read as zero.");

  a_global_gate: assert property (
    !keypad_global_enable |-> !expanded_external_interrupt)
    else $error("Interrupt raised with the global enable clear.");

  a_mask_gate: assert property (
    ((line_detect_flags_ff & line_enable_mask_ff) == '0) |-> !expanded_external_interrupt)
    else $error("Interrupt raised with no enabled flag.");

  a_level_path: assert property (
    ($stable(port_one_pins) && $stable(line_polarity_select_ff))[*3]
      |-> (level_match == ~(port_one_pins ^ line_polarity_select_ff)))
    else $error("Level comparison does not follow the synchronised pins.");

  a_pin_to_flag: assert property (
    ($stable(port_one_pins) && $stable(line_polarity_select_ff) && !rd_flags)[*4]
      |-> ((line_detect_flags_ff & ~(port_one_pins ^ line_polarity_select_ff))
           == ~(port_one_pins ^ line_polarity_select_ff)))
    else $error("Held matching level did not show in the flags.");

  a_wake_level: assert property (
    ((~(port_one_pins ^ line_polarity_select_ff) & line_enable_mask_ff) != '0)
      |-> wake_request)
    else $error("Enabled matching level gave no wake request.");

  c_irq_raised: cover property ($rose(expanded_external_interrupt));
  c_read_clear: cover property (rd_flags && line_detect_flags_ff != '0 ##1
    line_detect_flags_ff == '0);
  c_wake: cover property ($rose(wake_request));
  c_high_level: cover property (line_polarity_select_ff != '0 && level_match != '0);

endmodule

`default_nettype wire

/* File: tb/keypad_pins_model.sv */
`timescale 1ns/10ps
`default_nettype none

module keypad_pins_model (
  input wire logic [7:0] row_levels, // Levels the bench wants on the rows.
  output logic [7:0] port_pins // Raw pin levels seen by the unit.
);
  // Rows move off the clock grid, so the unit must synchronize them.
  // The first pass drives the initial rows, so the pins are unknown for the first 2 ns only.
  always begin
    port_pins <= #2 row_levels;
    @(row_levels);
  end
endmodule

`default_nettype wire

/* File: tb/keypad_level_interrupt_unit_tb.sv */
`timescale 1ns/10ps
`default_nettype none

module keypad_level_interrupt_unit_tb;
  import keypad_pkg::*;
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] row_levels = 8'h00;
  logic [LINE_COUNT-1:0] pins;
  sfr_addr_t sfr_addr = 8'h00;
  logic sfr_wr = 1'b0;
  logic sfr_rd = 1'b0;
  sfr_data_t sfr_wdata = 8'h00;
  sfr_data_t sfr_rdata;
  logic glb_en = 1'b0;
  logic irq;
  logic wake;
  logic [LINE_COUNT-1:0] alt;
  int fails = 0;
  int total_checks = 0;
  int m_pol = 0;
  int m_mask = 0;
  int m_flags = 0;
  logic [7:0] m_sync1 = 8'h00;
  logic [7:0] m_sync2 = 8'h00;
  logic [31:0] lfsr = 32'h6e75912d;

  always #2.5 sys_clk = ~sys_clk;

  // Flag model, cycle by cycle: two sampling stages, then a set wins over the read clear.
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      m_sync1 <= 8'h00;
      m_sync2 <= 8'h00;
      m_flags <= 0;
    end else begin
      m_sync1 <= row_levels;
      m_sync2 <= m_sync1;
      m_flags <= ((sfr_rd && sfr_addr == FLAGS_ADDR) ? 0 : m_flags)
        | (~(m_sync2 ^ m_pol[7:0]) & 8'hff);
    end
  end

  keypad_pins_model rows (.row_levels(row_levels), .port_pins(pins));

  keypad_level_interrupt_unit dut (.sys_clk(sys_clk), .rstn(rstn), .port_one_pins(pins),
    .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata),
    .sfr_rdata(sfr_rdata), .keypad_global_enable(glb_en),
    .expanded_external_interrupt(irq), .wake_request(wake), .line_alt_active(alt));

  //////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic int match();
    return ~(row_levels ^ m_pol[7:0]) & 8'hff;
  endfunction

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // A gap cycle follows each access so no strobe is lowered and raised in one step.
  task automatic sfr_write(input sfr_addr_t a, input sfr_data_t d);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    cyc(1);
    sfr_wr = 1'b0;
    if (a == POLARITY_ADDR) m_pol = d;
    if (a == ENABLE_ADDR) m_mask = d;
    cyc(1);
  endtask

  task automatic sfr_read(input sfr_addr_t a, input string nm);
    int exp;
    exp = (a == POLARITY_ADDR) ? m_pol : (a == ENABLE_ADDR) ? m_mask : UNMAPPED_READ;
    if (a == FLAGS_ADDR) exp = m_flags;
    sfr_addr = a;
    sfr_rd = 1'b1;
    cyc(1);
    sfr_rd = 1'b0;
    chk(nm, 8'(exp), sfr_rdata);
    cyc(1);
  endtask

  // Three edges carry a pin change to its flag; four leave margin for the pin delay.
  task automatic settle_and_check();
    cyc(4);
    chk("irq", {7'b0, ((m_flags & m_mask) != 0) && glb_en}, {7'b0, irq});
    chk("wake", {7'b0, (match() & m_mask) != 0}, {7'b0, wake});
    chk("alt", 8'(m_mask), alt);
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge sys_clk);
    fails++;
    print_verdict();
  end

  initial begin
    cyc(16);
    rstn = 1'b1;
    sfr_read(POLARITY_ADDR, "pol_reset");
    sfr_read(ENABLE_ADDR, "mask_reset");
    settle_and_check();
    sfr_read(FLAGS_ADDR, "flags_low");
    sfr_read(8'h80, "unmapped");
    for (int i = 0; i < 48; i++) begin
      lfsr = lfsr_next(lfsr);
      glb_en = lfsr[24];
      sfr_write(POLARITY_ADDR, lfsr[7:0]);
      sfr_write(ENABLE_ADDR, lfsr[15:8]);
      if (i % 8 == 3) begin
        sfr_read(ENABLE_ADDR, "mask_back");
        sfr_write(FLAGS_ADDR, 8'hff);
        sfr_write(8'h80, 8'h5a);
      end
      // Every fourth pass holds all rows away from their level, so a read really clears.
      row_levels = (i % 4 == 1) ? ~lfsr[7:0] : lfsr[23:16];
      settle_and_check();
      sfr_read(POLARITY_ADDR, "pol");
      sfr_read(ENABLE_ADDR, "mask");
      sfr_read(FLAGS_ADDR, "flags");
      chk("irq_after_read", {7'b0, ((m_flags & m_mask) != 0) && glb_en}, {7'b0, irq});
      sfr_read(FLAGS_ADDR, "flags_rearm");
    end
    print_verdict();
  end
endmodule

`default_nettype wire
